// ### src/ubp_pkg.sv
// shared constants and types of the serial unit
// assumes a 32-bit AXI4-Lite register bus and one clock
package ubp_pkg;

  // -----------------------------------------------------------------
  // bus geometry and register indices (byte address = index * 4)
  // -----------------------------------------------------------------
  localparam int          ADDR_W     = 18;
  localparam int          DATA_W     = 32;
  localparam logic [15:0] IDX_MODE   = 16'hFF70;
  localparam logic [15:0] IDX_STAT   = 16'hFF71;
  localparam logic [15:0] IDX_BAUD   = 16'hFF73;
  localparam logic [15:0] IDX_RXBUF  = 16'hFF74;
  localparam logic [15:0] IDX_TXDATA = 16'hFF75;
  localparam logic [15:0] IDX_LINE   = 16'hFF76;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // -----------------------------------------------------------------
  // reset values, write masks and fields
  // -----------------------------------------------------------------
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hFC;
  localparam logic [7:0] BAUD_WMASK = 8'hF0;
  localparam int MODE_TXE = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_PS_HI = 5;
  localparam int MODE_PS_LO = 4;
  localparam int MODE_CL = 3;
  localparam int MODE_SL = 2;
  localparam int BAUD_SEL_HI = 7;
  localparam int BAUD_SEL_LO = 4;
  localparam int LINE_TXBUSY = 0;
  localparam int LINE_RXFULL = 1;

  // -----------------------------------------------------------------
  // baud source and bit timing
  // -----------------------------------------------------------------
  localparam logic [3:0] SEL_SYS_MAX = 4'h7;
  localparam logic [3:0] SEL_EXT     = 4'h8;
  localparam logic [7:0] DIV_MASK    = 8'hFF;
  localparam logic [3:0] OVS_MID     = 4'h7;
  localparam logic [3:0] OVS_LAST    = 4'hF;
  localparam logic [2:0] LAST_BIT_7  = 3'h6;
  localparam logic [2:0] LAST_BIT_8  = 3'h7;

  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN}
    ubp_par_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    ubp_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    ubp_tx_state_t;

endpackage

// ### src/ubp_baud_gen.sv
// sixteen-fold oversampling tick from system clock or external pin
// assumes the external pin is synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module ubp_baud_gen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] sel,
  input  wire logic       ext_baud_clock_pin,
  output logic            tick_q
);

  logic [7:0] cnt_q;
  logic       pin_q;
  logic [7:0] mask;

  // -----------------------------------------------------------------
  // divider
  // -----------------------------------------------------------------
  // period two to the power of sel plus one
  assign mask = ubp_pkg::DIV_MASK >> (3'(ubp_pkg::SEL_SYS_MAX - sel));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      pin_q <= ext_baud_clock_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
    end else if (sel <= ubp_pkg::SEL_SYS_MAX) begin
      tick_q <= ((cnt_q & mask) == mask);
    end else if (sel == ubp_pkg::SEL_EXT) begin
      tick_q <= ext_baud_clock_pin & ~pin_q;
    end else begin
      tick_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_baud_prohib_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sel > ubp_pkg::SEL_EXT) && $past(sel > ubp_pkg::SEL_EXT) |-> !tick_q)
    else $error("tick on prohibited source code");

endmodule // ubp_baud_gen
`default_nettype wire

// ### src/ubp_rx.sv
// receive path: start detect, centre sampling, parity and stop check
// assumes tick is the sixteen-fold oversampling enable
`timescale 1ns/1ps
`default_nettype none
module ubp_rx (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic [1:0] ps,
  input  wire logic       cl,
  output logic            done_q,
  output logic [7:0]      data_q,
  output logic            pe_q,
  output logic            fe_q
);

  ubp_pkg::ubp_rx_state_t state_q;
  logic [3:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] shift_q;
  logic       par_q;
  logic       bit_end;

  assign bit_end = tick && (cnt_q == ubp_pkg::OVS_LAST);

  // -----------------------------------------------------------------
  // frame sequencing
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_q <= ubp_pkg::RX_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= 3'h0;
      shift_q <= 8'h00;
      par_q   <= 1'b0;
    end else begin
      if (tick) begin
        cnt_q <= cnt_q + 4'h1;
      end
      case (state_q)
        ubp_pkg::RX_IDLE: begin
          if (!rxd) begin
            state_q <= ubp_pkg::RX_START;
            cnt_q   <= 4'h0;
          end
        end
        ubp_pkg::RX_START: begin
          if (tick && cnt_q == ubp_pkg::OVS_MID) begin
            cnt_q   <= 4'h0;
            idx_q   <= 3'h0;
            shift_q <= 8'h00;
            state_q <= rxd ? ubp_pkg::RX_IDLE : ubp_pkg::RX_DATA;
          end
        end
        ubp_pkg::RX_DATA: begin
          if (bit_end) begin
            shift_q[idx_q] <= rxd;
            idx_q <= idx_q + 3'h1;
            if (idx_q == (cl ? ubp_pkg::LAST_BIT_8 : ubp_pkg::LAST_BIT_7))
            begin
              state_q <= (ps == ubp_pkg::PAR_NONE) ? ubp_pkg::RX_STOP
                                                   : ubp_pkg::RX_PAR;
            end
          end
        end
        ubp_pkg::RX_PAR: begin
          if (bit_end) begin
            par_q   <= rxd;
            state_q <= ubp_pkg::RX_STOP;
          end
        end
        ubp_pkg::RX_STOP: begin
          if (bit_end) begin
            state_q <= ubp_pkg::RX_IDLE;
          end
        end
        default: state_q <= ubp_pkg::RX_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // frame result
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      data_q <= 8'h00;
      pe_q   <= 1'b0;
      fe_q   <= 1'b0;
    end else begin
      done_q <= enable && bit_end && (state_q == ubp_pkg::RX_STOP);
      if (enable && bit_end && state_q == ubp_pkg::RX_STOP) begin
        data_q <= shift_q;
        fe_q <= !rxd;
        case (ps)
          ubp_pkg::PAR_ODD:  pe_q <= ~(^{shift_q, par_q});
          ubp_pkg::PAR_EVEN: pe_q <= ^{shift_q, par_q};
          default:           pe_q <= 1'b0;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_rx_msb_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    done_q && !cl |-> !data_q[7])
    else $error("bit 7 set in seven-bit frame");

  a_rx_no_parity: assert property (
    @(posedge aclk) disable iff (!aresetn)
    done_q && !ps[1] && $past(!ps[1]) |-> !pe_q)
    else $error("parity error without parity check");

endmodule // ubp_rx
`default_nettype wire

// ### src/ubp_uart.sv
// serial unit top: AXI4-Lite registers, transmitter, error status
// assumes one clock aclk at 40 MHz and synchronous serial inputs
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ubp_uart (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ubp_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [ubp_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       rxd,
  output logic                            txd,
  input  wire logic                       ext_baud_clock_pin
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [7:0]  mode_q;
  logic [7:0]  baud_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [15:0] wr_idx_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic        wr_fire;
  logic        wr_ok;
  logic [15:0] rd_idx;
  logic        ar_hs;
  logic        buf_rd;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic        pe_q;
  logic        fe_q;
  logic        ove_q;
  logic [7:0]  rx_buf_q;
  logic        rx_full_q;
  logic        tick;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_pe;
  logic        rx_fe;
  ubp_pkg::ubp_tx_state_t tx_state_q;
  logic [3:0]  tx_cnt_q;
  logic [2:0]  tx_idx_q;
  logic [7:0]  tx_shift_q;
  logic        tx_par_q;
  logic        tx_stop2_q;
  logic        tx_start;
  logic        tx_end;
  logic [7:0]  tx_char;
  logic [1:0]  ps;
  logic        cl;

  assign ps = mode_q[ubp_pkg::MODE_PS_HI:ubp_pkg::MODE_PS_LO];
  assign cl = mode_q[ubp_pkg::MODE_CL];

  // -----------------------------------------------------------------
  // submodules
  // -----------------------------------------------------------------
  ubp_baud_gen u_baud (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .sel                (baud_q[ubp_pkg::BAUD_SEL_HI:ubp_pkg::BAUD_SEL_LO]),
    .ext_baud_clock_pin (ext_baud_clock_pin),
    .tick_q             (tick)
  );

  ubp_rx u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (mode_q[ubp_pkg::MODE_RXE]),
    .tick    (tick),
    .rxd     (rxd),
    .ps      (ps),
    .cl      (cl),
    .done_q  (rx_done),
    .data_q  (rx_data),
    .pe_q    (rx_pe),
    .fe_q    (rx_fe)
  );

  // -----------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid;
  assign wr_ok   = wlane_q && (wr_idx_q == ubp_pkg::IDX_MODE ||
                               wr_idx_q == ubp_pkg::IDX_BAUD ||
                               wr_idx_q == ubp_pkg::IDX_TXDATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      aw_hold_q <= 1'b0;
      wr_idx_q  <= 16'h0000;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_hold_q <= 1'b1;
      wr_idx_q  <= awaddr[ubp_pkg::ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end else if (!aw_hold_q && !bvalid) begin
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready   <= 1'b0;
      w_hold_q <= 1'b0;
      wdata_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end else if (wvalid && wready) begin
      wready   <= 1'b0;
      w_hold_q <= 1'b1;
      wdata_q  <= wdata[7:0];
      wlane_q  <= wstrb[0];
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end else if (!w_hold_q && !bvalid) begin
      wready   <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= ubp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? ubp_pkg::RESP_OKAY : ubp_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= ubp_pkg::MODE_RST;
    end else if (wr_fire && wlane_q && wr_idx_q == ubp_pkg::IDX_MODE) begin
      mode_q <= wdata_q & ubp_pkg::MODE_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_q <= ubp_pkg::BAUD_RST;
    end else if (wr_fire && wlane_q && wr_idx_q == ubp_pkg::IDX_BAUD) begin
      baud_q <= wdata_q & ubp_pkg::BAUD_WMASK;
    end
  end

  // -----------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------
  assign ar_hs  = arvalid && arready;
  assign rd_idx = araddr[ubp_pkg::ADDR_W-1:2];
  assign buf_rd = ar_hs && (rd_idx == ubp_pkg::IDX_RXBUF);

  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (rd_idx)
      ubp_pkg::IDX_MODE:   rd_byte = mode_q;
      ubp_pkg::IDX_STAT:   rd_byte = {5'h00, pe_q, fe_q, ove_q};
      ubp_pkg::IDX_BAUD:   rd_byte = baud_q;
      ubp_pkg::IDX_RXBUF:  rd_byte = rx_buf_q;
      ubp_pkg::IDX_TXDATA: rd_byte = tx_shift_q;
      ubp_pkg::IDX_LINE: begin
        rd_byte[ubp_pkg::LINE_TXBUSY] = (tx_state_q != ubp_pkg::TX_IDLE);
        rd_byte[ubp_pkg::LINE_RXFULL] = rx_full_q;
      end
      default:             rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ubp_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_byte};
      rresp   <= rd_ok ? ubp_pkg::RESP_OKAY : ubp_pkg::RESP_SLVERR;
    end else if (rvalid) begin
      rvalid  <= !rready;
    end else begin
      arready <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // receive buffer and error status
  // -----------------------------------------------------------------
  // flags move with the buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
      pe_q      <= 1'b0;
      fe_q      <= 1'b0;
      ove_q     <= 1'b0;
    end else if (rx_done) begin
      rx_buf_q  <= rx_data;
      rx_full_q <= 1'b1;
      pe_q      <= rx_pe;
      fe_q      <= rx_fe;
      ove_q     <= rx_full_q && !buf_rd;
    end else if (buf_rd) begin
      rx_full_q <= 1'b0;
      pe_q      <= 1'b0;
      fe_q      <= 1'b0;
      ove_q     <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // transmitter
  // -----------------------------------------------------------------
  // bit 7 dropped in seven-bit mode
  assign tx_char  = cl ? wdata_q : {1'b0, wdata_q[6:0]};
  assign tx_start = wr_fire && wlane_q && wr_idx_q == ubp_pkg::IDX_TXDATA
                    && mode_q[ubp_pkg::MODE_TXE]
                    && tx_state_q == ubp_pkg::TX_IDLE;
  assign tx_end   = tick && (tx_cnt_q == ubp_pkg::OVS_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || !mode_q[ubp_pkg::MODE_TXE]) begin
      tx_state_q <= ubp_pkg::TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_idx_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else begin
      if (tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      case (tx_state_q)
        ubp_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state_q <= ubp_pkg::TX_START;
            tx_cnt_q   <= 4'h0;
            tx_idx_q   <= 3'h0;
            tx_shift_q <= tx_char;
            tx_stop2_q <= mode_q[ubp_pkg::MODE_SL];
            case (ps)
              ubp_pkg::PAR_ODD:  tx_par_q <= ~(^tx_char);
              ubp_pkg::PAR_EVEN: tx_par_q <= ^tx_char;
              default:           tx_par_q <= 1'b0;
            endcase
          end
        end
        ubp_pkg::TX_START: begin
          if (tx_end) begin
            tx_state_q <= ubp_pkg::TX_DATA;
          end
        end
        ubp_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_idx_q   <= tx_idx_q + 3'h1;
            if (tx_idx_q == (cl ? ubp_pkg::LAST_BIT_8 : ubp_pkg::LAST_BIT_7))
            begin
              tx_state_q <= (ps == ubp_pkg::PAR_NONE) ? ubp_pkg::TX_STOP
                                                      : ubp_pkg::TX_PAR;
            end
          end
        end
        ubp_pkg::TX_PAR: begin
          if (tx_end) begin
            tx_state_q <= ubp_pkg::TX_STOP;
          end
        end
        ubp_pkg::TX_STOP: begin
          if (tx_end) begin
            tx_stop2_q <= 1'b0;
            if (!tx_stop2_q) begin
              tx_state_q <= ubp_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_q <= ubp_pkg::TX_IDLE;
      endcase
    end
  end

  // line level follows the state one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1;
    end else begin
      case (tx_state_q)
        ubp_pkg::TX_START: txd <= 1'b0;
        ubp_pkg::TX_DATA:  txd <= tx_shift_q[0];
        ubp_pkg::TX_PAR:   txd <= tx_par_q;
        default:           txd <= 1'b1;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_status_read_val: assert property (
    ar_hs && rd_idx == ubp_pkg::IDX_STAT |=>
      rdata[31:3] == 29'h0000_0000 &&
      rdata[2:0] == $past({pe_q, fe_q, ove_q}))
    else $error("status read value wrong");

  a_overrun_set: assert property (
    rx_done && rx_full_q && !buf_rd |=> ove_q)
    else $error("overrun not flagged");

  a_overrun_keep: assert property (
    ove_q && rx_done && !buf_rd |=> ove_q && rx_full_q)
    else $error("overrun not repeated");

  a_err_clear_read: assert property (
    buf_rd && !rx_done |=> !pe_q && !fe_q && !ove_q && !rx_full_q)
    else $error("flags not cleared by buffer read");

  a_frame_copy: assert property (
    rx_done |=> fe_q == $past(rx_fe) && pe_q == $past(rx_pe) &&
      rx_buf_q == $past(rx_data))
    else $error("flags not updated with buffer");

  a_baud_whole_byte: assert property (
    wr_fire && !wlane_q |=> $stable(baud_q) && $stable(mode_q))
    else $error("partial write changed a register");

  a_tx_start_low: assert property (
    tx_state_q == ubp_pkg::TX_START |=> !txd)
    else $error("start bit not low");

  a_tx_parity_bit: assert property (
    tx_state_q == ubp_pkg::TX_PAR |=> txd == $past(tx_par_q))
    else $error("parity bit not driven");

  c_overrun: cover property (rx_done && rx_full_q);
  c_frame_err: cover property (rx_done && rx_fe);
  c_parity_err: cover property (rx_done && rx_pe);
  c_tx_done: cover property (
    tx_state_q == ubp_pkg::TX_STOP ##1 tx_state_q == ubp_pkg::TX_IDLE);

endmodule // ubp_uart
`default_nettype wire

// ### test/ubp_remote.sv
// remote serial transceiver model
// assumes bit time in aclk cycles from caller
`timescale 1ns/1ps
`default_nettype none
module ubp_remote (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic send(input int bc, input logic [8:0] b, input int n,
                      input logic st);
    rxd <= 1'b0;
    repeat (bc) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (bc) @(posedge aclk);
    end
    rxd <= st;
    repeat (bc * 5 / 8) @(posedge aclk);
    rxd <= 1'b1;
    repeat (bc * 2) @(posedge aclk);
  endtask
  task automatic grab(input int bc, output logic [10:0] f);
    while (txd !== 1'b0) @(posedge aclk);
    repeat (bc / 2) @(posedge aclk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      repeat (bc) @(posedge aclk);
    end
  endtask
endmodule // ubp_remote
`default_nettype wire

// ### test/uart_baud_parity_status_tb_top.sv
// testbench: register bus, receive errors, parity, baud sources
// assumes ubp_uart at 40 MHz with the remote model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module uart_baud_parity_status_tb_top;
  localparam logic [15:0] MD = ubp_pkg::IDX_MODE, ST = ubp_pkg::IDX_STAT;
  localparam logic [15:0] BD = ubp_pkg::IDX_BAUD, RB = ubp_pkg::IDX_RXBUF;
  localparam logic [15:0] TD = ubp_pkg::IDX_TXDATA, LN = ubp_pkg::IDX_LINE;
  localparam logic [1:0]  OK = ubp_pkg::RESP_OKAY;
  localparam logic [1:0]  SE = ubp_pkg::RESP_SLVERR;
  logic        aclk = '0, aresetn = '0, ext_baud_clock_pin = '0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = '0, wvalid = '0, bready = '0;
  logic        arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, txd, rxd;
  logic [1:0]  bresp, rresp;
  logic [10:0] f;
  int          n_mismatch = 0;
  int          checked = 0;
  ubp_uart i_dut (.*);
  ubp_remote i_remote (.*);
  always #12.5 aclk = ~aclk;
  always begin
    repeat (3) @(posedge aclk);
    ext_baud_clock_pin <= ~ext_baud_clock_pin;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e,
                    input logic [1:0] er = OK);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(ST, 8'h00);
    rd(BD, 8'h00);
    wr(ST, 8'hFF, 4'hF, SE);
    wr(BD, 8'h10, 4'h2, SE);
    wr(16'h0001, 8'h55, 4'hF, SE);
    rd(16'h0001, 8'h00, SE);
    rd(ST, 8'h00);
    rd(BD, 8'h00);
  endtask
  task automatic t_par();
    logic [7:0] md [5] = '{8'h78, 8'h78, 8'h68, 8'h58, 8'h48};
    logic [7:0] es [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
    logic [4:0] pb = 5'h0A;
    for (int k = 0; k < 5; k++) begin
      wr(MD, md[k], 4'hF, OK);
      i_remote.send(32, {pb[k], 8'hA5}, (k == 4) ? 8 : 9, 1'b1);
      rd(ST, es[k]);
      rd(RB, 8'hA5);
    end
  endtask
  task automatic t_frm();
    wr(MD, 8'h7C, 4'hF, OK);
    i_remote.send(32, {1'b0, 8'h3C}, 9, 1'b0);
    rd(ST, 8'h02);
    rd(RB, 8'h3C);
    i_remote.send(32, {1'b0, 8'h3C}, 9, 1'b1);
    rd(ST, 8'h00);
    rd(RB, 8'h3C);
  endtask
  task automatic t_ovr();
    wr(MD, 8'h78, 4'hF, OK);
    repeat (2) i_remote.send(32, {1'b0, 8'h3C}, 9, 1'b1);
    rd(ST, 8'h01);
    i_remote.send(32, {1'b1, 8'hA5}, 9, 1'b1);
    rd(ST, 8'h05);
    rd(RB, 8'hA5);
    rd(ST, 8'h00);
  endtask
  task automatic t_7b();
    wr(MD, 8'h70, 4'hF, OK);
    i_remote.send(32, {2'b01, 7'h7F}, 8, 1'b1);
    rd(ST, 8'h00);
    rd(RB, 8'h7F);
  endtask
  task automatic t_tx();
    logic [7:0]  md [4] = '{8'hB8, 8'hA8, 8'hB0, 8'hBC};
    logic [7:0]  dt [4] = '{8'h07, 8'h07, 8'h87, 8'h07};
    logic [10:0] ef [4] = '{11'h60E, 11'h40E, 11'h70E, 11'h60E};
    for (int k = 0; k < 4; k++) begin
      wr(MD, md[k], 4'hF, OK);
      fork
        wr(TD, dt[k], 4'hF, OK);
        i_remote.grab(32, f);
      join
      chk({21'h0, f}, {21'h0, ef[k]});
      rd(LN, (k == 3) ? 8'h01 : 8'h00);
      repeat (32) @(posedge aclk);
    end
  endtask
  task automatic t_baud();
    logic [7:0] sel [2] = '{8'h10, 8'h80};
    int         bc [2] = '{64, 96};
    wr(MD, 8'h78, 4'hF, OK);
    for (int k = 0; k < 2; k++) begin
      wr(BD, sel[k], 4'hF, OK);
      rd(BD, sel[k]);
      i_remote.send(bc[k], {1'b0, 8'h3C}, 9, 1'b1);
      rd(ST, 8'h00);
      rd(RB, 8'h3C);
    end
    wr(BD, 8'h90, 4'hF, OK);
    rd(BD, 8'h90);
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    $display("reset done");
    t_par();
    $display("parity done");
    t_frm();
    $display("framing done");
    t_ovr();
    $display("overrun done");
    t_7b();
    $display("seven bit done");
    t_tx();
    $display("transmit done");
    t_baud();
    $display("baud done");
    close_out();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule // uart_baud_parity_status_tb_top
`default_nettype wire
